// ===== bench/abu_breakpoint_unit_asserts.sv
// port checker of the breakpoint unit
`timescale 1ns/10ps
module abu_checker (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire abu_pkg::abu_data_ref_s  data_ref,
  input wire abu_pkg::abu_fetch_ref_s fetch_ref,
  input wire abu_pkg::abu_exc_s       exc,
  input wire logic                   debug_pulse,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_dsi_cause; exc.data_storage_int |-> exc.storage_fault_cause[22]; endproperty
  a_dsi_cause: assert property (p_dsi_cause) else $error("cause bit missing");
  property p_dsi_addr;
    exc.data_storage_int |-> exc.fault_location_reg == $past(data_ref.effective_location);
  endproperty
  a_dsi_addr: assert property (p_dsi_addr) else $error("fault address wrong");
  property p_dsi_src;
    exc.data_storage_int |-> $past(data_ref.valid) && !$past(data_ref.higher_trap)
      && $past(data_ref.size) != 6'h00;
  endproperty
  a_dsi_src: assert property (p_dsi_src) else $error("storage int without cause");
  property p_dsi_kind;
    exc.data_storage_int |-> !($past(data_ref.kind) inside
      {abu_pkg::ABU_REF_NONE, abu_pkg::ABU_REF_CACHE_OP});
  endproperty
  a_dsi_kind: assert property (p_dsi_kind) else $error("storage int on cache op");
  property p_tr_bit; exc.trace_int |-> exc.saved_state_reg[20]; endproperty
  a_tr_bit: assert property (p_tr_bit) else $error("saved state bit missing");
  property p_tr_src;
    exc.trace_int |-> $past(fetch_ref.valid) && !$past(fetch_ref.higher_trap);
  endproperty
  a_tr_src: assert property (p_tr_src) else $error("trace int without fetch");
  // a bus cycle spans several core cycles, so the pin cannot flicker
  property p_pulse; $changed(debug_pulse) |=> $stable(debug_pulse) [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("debug pin glitch");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("read response repeated");
  c_dsi: cover property (exc.data_storage_int);
  c_trace: cover property (exc.trace_int);
  c_pulse: cover property ($changed(debug_pulse));
endmodule
bind abu_breakpoint_unit abu_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .data_ref(data_ref), .fetch_ref(fetch_ref), .exc(exc), .debug_pulse(debug_pulse),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== bench/abu_far_side.sv
// far side model: free running bus clock and debug pin observer
`timescale 1ns/10ps
module abu_far_side (
  input  wire logic aclk,
  input  wire logic debug_pulse,
  input  wire logic idle_level,
  output logic      bus_tick,
  output int        pulse_count
);
  logic seen;
  // bus clock at a quarter of the core rate, phase unrelated to aclk
  initial begin
    bus_tick = 1'b0;
    #7;
    forever #80 bus_tick = ~bus_tick;
  end
  // one count per departure from the idle level, so merged hits count once
  always @(posedge aclk) begin
    seen <= (debug_pulse !== idle_level);
    if ((debug_pulse !== idle_level) && !seen) pulse_count <= pulse_count + 1;
  end
endmodule

// ===== bench/address_breakpoint_unit_tb.sv
// self checking bench of the breakpoint unit
`timescale 1ns/10ps
module address_breakpoint_unit_tb;
  logic                   aclk, aresetn, bus_tick, debug_pulse, idle;
  abu_pkg::abu_data_ref_s  dr;
  abu_pkg::abu_fetch_ref_s fr;
  abu_pkg::abu_exc_s       exc;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic                   awv, awr, wv, wrdy, br, bv, arv, arr, rv, rr;
  logic [1:0]             bresp, rresp;
  int                     err_total, total_checks, pulse_count, n;
  abu_breakpoint_unit #(.PULSE_DELAY(1)) uut (.aclk(aclk), .aresetn(aresetn),
    .bus_tick(bus_tick), .data_ref(dr), .fetch_ref(fr), .exc(exc), .debug_pulse(debug_pulse),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  abu_far_side far (.aclk(aclk), .debug_pulse(debug_pulse), .idle_level(idle),
    .bus_tick(bus_tick), .pulse_count(pulse_count));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awv && awr === 1'b1) begin ta = 1'b1; awv <= 1'b0; end
      if (wv && wrdy === 1'b1) begin tw = 1'b1; wv <= 1'b0; end
    end
    while (bv !== 1'b1) @(posedge aclk);
    br <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge aclk);
    rr <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask
  // one reference, then the registered exception one cycle later
  task automatic dref(input int k, input logic [31:0] ea, input logic [5:0] sz,
                      input logic dx, input logic um, input logic ht, input logic exp);
    @(posedge aclk);
    dr <= '{1'b1, abu_pkg::abu_ref_e'(k), ea, sz, ht, dx, um};
    @(posedge aclk);
    dr.valid <= 1'b0;
    @(negedge aclk);
    chk(exc.data_storage_int, exp);
    chk(exc.storage_fault_cause[22], exp);
    if (exp) chk(exc.fault_location_reg, ea);
  endtask
  task automatic fref(input logic [31:0] loc, input logic fx, input logic ht, input logic exp);
    @(posedge aclk);
    fr <= '{1'b1, loc, ht, fx};
    @(posedge aclk);
    fr.valid <= 1'b0;
    @(negedge aclk);
    chk(exc.trace_int, exp);
    chk(exc.saved_state_reg[20], exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h08, 32'h0, 2'b00);
    wr(8'h00, 32'hffff_ffff, 2'b00);
    rd(8'h00, 32'h0000_01ff, 2'b00);
    wr(8'h08, 32'h89ab_cdef, 2'b00);
    rd(8'h08, 32'h89ab_cdef, 2'b00);
    wr(8'h14, 32'h0000_0001, 2'b10);
    rd(8'h18, 32'h0, 2'b10);
  endtask
  task automatic t_compat;
    wr(8'h08, 32'hffff_ffff, 2'b00);
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h0c, 32'h1234_5677, 2'b00);
    rd(8'h08, 32'h1234_5670, 2'b00);
    rd(8'h00, 32'h0000_001f, 2'b00);
    rd(8'h0c, 32'h1234_5677, 2'b00);
    wr(8'h00, 32'h0000_0005, 2'b00);
    rd(8'h0c, 32'h1234_5675, 2'b00);
  endtask
  // every mask against every byte of the doubleword and the first byte of the next one
  task automatic t_mask;
    wr(8'h08, 32'h1000_0005, 2'b00);
    for (int m = 0; m < 8; m++) begin
      wr(8'h00, {23'h0, m[2:0], 6'h19}, 2'b00);
      repeat (2) @(posedge aclk);
      for (int a = 0; a < 9; a++)
        dref(1, 32'h1000_0000 + a, 6'd1, 1'b0, 1'b0, 1'b0, a < 8 && ((a ^ 5) & m) == 0);
    end
    rd(8'h14, 32'h0000_001b, 2'b00); // every hit of the sweep counted once
  endtask
  // all qualifier settings against all states and reference kinds
  task automatic t_qual;
    logic e;
    wr(8'h08, 32'h2000_0010, 2'b00);
    for (int c = 0; c < 32; c++) begin
      wr(8'h00, {23'h0, 3'h7, 1'b0, c[4:0]}, 2'b00);
      repeat (2) @(posedge aclk);
      for (int q = 0; q < 24; q++) begin
        e = (c[2] == q[0]) && ((c[4] && q[1]) || (c[3] && !q[1]))
          && ((c[0] && q[4:2] == 1) || (c[1] && q[4:2] inside {2, 3, 5}));
        if (q[4:2] == 3) dref(3, 32'h2000_0000, 6'd32, q[0], q[1], 1'b0, e);
        else dref(q[4:2], 32'h2000_000e, 6'd4, q[0], q[1], 1'b0, e);
      end
    end
    wr(8'h00, 32'h0000_0019, 2'b00);
    dref(1, 32'h2000_0010, 6'd1, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_fetch;
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h04, 32'h0000_4003, 2'b00);
    fref(32'h0000_4000, 1'b1, 1'b0, 1'b1);
    fref(32'h0000_4002, 1'b1, 1'b0, 1'b1);
    fref(32'h0000_4004, 1'b1, 1'b0, 1'b0);
    fref(32'h0000_4000, 1'b0, 1'b0, 1'b0);
    fref(32'h0000_4000, 1'b1, 1'b1, 1'b0);
    wr(8'h04, 32'h0000_4001, 2'b00);
    fref(32'h0000_4000, 1'b1, 1'b0, 1'b0);
  endtask
  // pin mode: no exceptions, one pulse per isolated hit, close hits merge
  task automatic t_strobe;
    wr(8'h10, 32'h0000_0001, 2'b00);
    idle <= 1'b1;
    wr(8'h00, 32'h0000_01f9, 2'b00);
    wr(8'h04, 32'h0000_4003, 2'b00);
    chk(debug_pulse, 1'b1);
    n = pulse_count;
    dref(1, 32'h2000_0010, 6'd1, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (80) @(posedge aclk);
    chk(pulse_count, n + 1);
    dref(1, 32'h2000_0010, 6'd1, 1'b0, 1'b0, 1'b1, 1'b0);
    repeat (80) @(posedge aclk);
    chk(pulse_count, n + 1);
    dref(1, 32'h2000_0010, 6'd1, 1'b0, 1'b0, 1'b0, 1'b0);
    dref(1, 32'h2000_0010, 6'd1, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (80) @(posedge aclk);
    chk(pulse_count, n + 2);
    wr(8'h10, 32'h0, 2'b00);
    idle <= 1'b0;
    @(negedge aclk);
    chk(debug_pulse, 1'b0);
    fref(32'h0000_4000, 1'b1, 1'b0, 1'b0);
    repeat (80) @(posedge aclk);
    chk(pulse_count, n + 3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset for six cycles, then the scenarios in turn
  initial begin
    {aresetn, awv, wv, br, arv, rr, idle} = '0;
    {dr, fr, awaddr, araddr, wdata} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_compat();
    t_mask();
    t_qual();
    t_fetch();
    t_strobe();
    finish_test();
  end
  // the scenarios need well under 20000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    finish_test();
  end
endmodule

// ===== common/abu_pkg.sv
// types shared by the breakpoint unit
package abu_pkg;
  typedef enum logic [2:0] {
    ABU_REF_NONE,
    ABU_REF_LOAD,
    ABU_REF_STORE,
    ABU_REF_ZERO_BLOCK,
    ABU_REF_CACHE_OP,
    ABU_REF_COND_STORE
  } abu_ref_e;
  typedef struct packed {
    logic        valid;
    abu_ref_e    kind;
    logic [31:0] effective_location;
    logic [5:0]  size;
    logic        higher_trap;
    logic        data_xlate_on;
    logic        user_mode_flag;
  } abu_data_ref_s;
  typedef struct packed {
    logic        valid;
    logic [31:0] location;
    logic        higher_trap;
    logic        fetch_xlate_on;
  } abu_fetch_ref_s;
  typedef struct packed {
    logic        data_storage_int;
    logic [31:0] storage_fault_cause;
    logic [31:0] fault_location_reg;
    logic        trace_int;
    logic [31:0] saved_state_reg;
  } abu_exc_s;
endpackage

// ===== common/abu_regs.svh
// register offsets, field positions, reset values and timing counts of the breakpoint unit
`ifndef ABU_REGS_SVH
`define ABU_REGS_SVH
`define ABU_OFF_CONTROL      8'h00
`define ABU_OFF_FETCH_TARGET 8'h04
`define ABU_OFF_DATA_FULL    8'h08
`define ABU_OFF_COMPAT_VIEW  8'h0c
`define ABU_OFF_PULSE_CFG    8'h10
`define ABU_OFF_STATUS       8'h14
// big-endian numbering: bit n of the docs is lsb bit 31-n
`define ABU_MASK_HI          8
`define ABU_MASK_LO          6
`define ABU_PIN_SEL_BIT      5
`define ABU_USER_BIT         4
`define ABU_PRIV_BIT         3
`define ABU_DXLATE_BIT       2
`define ABU_WRITE_BIT        1
`define ABU_LOAD_BIT         0
`define ABU_IBP_EN_BIT       1
`define ABU_IXLATE_BIT       0
`define ABU_FAULT_CAUSE_BIT  22
`define ABU_SAVED_TRACE_BIT  20
`define ABU_CTRL_RESET       32'h0000_0000
`define ABU_TARGET_RESET     32'h0000_0000
`define ABU_CTRL_WMASK       32'h0000_01ff
`define ABU_PULSE_DELAY      3
`endif

// ===== src/abu_breakpoint_unit.sv
// address breakpoint unit: registers over axi4-lite, match logic, exception and strobe
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "abu_regs.svh"
// bit numbering: documented bit n of a register is lsb bit 31-n here
// pipeline side: one data and one fetch reference per clock, level qualified
// pin side: bus_tick is the bus clock sampled as data, three flops deep
// status word counts cycles with a hit that would have been taken, in either mode
module abu_breakpoint_unit #(
  parameter int PULSE_DELAY = `ABU_PULSE_DELAY
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   bus_tick,
  input  wire abu_pkg::abu_data_ref_s  data_ref,
  input  wire abu_pkg::abu_fetch_ref_s fetch_ref,
  output abu_pkg::abu_exc_s           exc,
  output logic                        debug_pulse,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  // software-visible state
  logic [31:0] bp_control;
  logic [31:0] fetch_bp_target;
  logic [31:0] data_bp_target_full;
  logic        pulse_idle_level;
  logic [31:0] hit_count;
  // write address and data held until both halves are in
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  // bus-cycle tick synchroniser and pulse sequencer
  logic        bus_tick_s1;
  logic        bus_tick_s2;
  logic        bus_tick_s3;
  logic        strobe_req;
  logic [3:0]  delay_cnt;
  logic        pulse_active;

  // merge byte strobes into an old word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // decode an offset; unmapped answers slverr
  function automatic logic mapped(input logic [7:0] a);
    return a == `ABU_OFF_CONTROL || a == `ABU_OFF_FETCH_TARGET || a == `ABU_OFF_DATA_FULL ||
           a == `ABU_OFF_COMPAT_VIEW || a == `ABU_OFF_PULSE_CFG || a == `ABU_OFF_STATUS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // data and fetch breakpoint match
  logic [2:0]  cmp_mask;
  logic [31:0] ref_first;
  logic [31:0] ref_last;
  logic [7:0]  byte_hit;
  logic        addr_hit;
  logic        kind_hit;
  logic        data_hit;
  logic        fetch_hit;
  logic        any_hit;

  always_comb begin
    cmp_mask = bp_control[`ABU_MASK_HI:`ABU_MASK_LO];
    // zero-block covers the whole 32-byte block for any nonzero size
    if (data_ref.kind == abu_pkg::ABU_REF_ZERO_BLOCK) begin
      ref_first = {data_ref.effective_location[31:5], 5'b0_0000};
      ref_last  = {data_ref.effective_location[31:5], 5'b1_1111};
    end else begin
      ref_first = data_ref.effective_location;
      // a reference running past the top of the address space would wrap here;
      // the pipeline never issues one, so the overlap test does not guard it
      ref_last  = data_ref.effective_location + {26'h000_0000, data_ref.size} - 32'h0000_0001;
    end
    // any matching byte inside the reference is a hit; zero bytes touch nothing
    addr_hit = (|byte_hit) && (data_ref.size != 6'd0);
    case (data_ref.kind)
      abu_pkg::ABU_REF_LOAD:       kind_hit = bp_control[`ABU_LOAD_BIT];
      abu_pkg::ABU_REF_STORE:      kind_hit = bp_control[`ABU_WRITE_BIT];
      abu_pkg::ABU_REF_ZERO_BLOCK: kind_hit = bp_control[`ABU_WRITE_BIT];
      abu_pkg::ABU_REF_COND_STORE: kind_hit = bp_control[`ABU_WRITE_BIT];
      default:                     kind_hit = 1'b0;
    endcase
    // kind, translation and mode bits also qualify data hits; strictly mask-independent for fetches
    data_hit = data_ref.valid && addr_hit && kind_hit
             && (data_ref.data_xlate_on == bp_control[`ABU_DXLATE_BIT])
             && ((bp_control[`ABU_USER_BIT] && data_ref.user_mode_flag)
              || (bp_control[`ABU_PRIV_BIT] && !data_ref.user_mode_flag));
    fetch_hit = fetch_ref.valid && fetch_bp_target[`ABU_IBP_EN_BIT]
              && (fetch_ref.location[31:2] == fetch_bp_target[31:2])
              && (fetch_ref.fetch_xlate_on == fetch_bp_target[`ABU_IXLATE_BIT]);
    // a higher-priority trap on the same operation wins over the break
    any_hit = (data_hit && !data_ref.higher_trap) || (fetch_hit && !fetch_ref.higher_trap);
  end

  // one candidate byte per position of the target doubleword; the mask may
  // leave holes in the matching set, so a single range test is not enough
  for (genvar j = 0; j < 8; j++) begin : g_byte
    logic [31:0] cand;
    assign cand        = {data_bp_target_full[31:3], 3'(j)};
    assign byte_hit[j] = ((3'(j) ^ data_bp_target_full[2:0]) & cmp_mask) == 3'b000
                       && cand >= ref_first && cand <= ref_last;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // exception outputs, registered one cycle after the reference
  // breakpoints rank below every other storage fault: a trap flagged on the
  // same reference wins and the break is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exc <= '0;
    end else begin
      exc <= '0;
      if (!bp_control[`ABU_PIN_SEL_BIT]) begin
        if (data_hit && !data_ref.higher_trap) begin
          exc.data_storage_int                          <= 1'b1;
          exc.storage_fault_cause[`ABU_FAULT_CAUSE_BIT] <= 1'b1;
          exc.fault_location_reg                        <= data_ref.effective_location;
        end
        if (fetch_hit && !fetch_ref.higher_trap) begin
          exc.trace_int                              <= 1'b1;
          exc.saved_state_reg[`ABU_SAVED_TRACE_BIT]  <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus-cycle tick comes from the bus clock domain: synchronise and edge-detect
  // the first stage may go metastable, so only the second and third ones feed logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_tick_s1 <= 1'b0;
      bus_tick_s2 <= 1'b0;
      bus_tick_s3 <= 1'b0;
    end else begin
      bus_tick_s1 <= bus_tick;
      bus_tick_s2 <= bus_tick_s1;
      bus_tick_s3 <= bus_tick_s2;
    end
  end

  logic bus_edge;
  assign bus_edge = bus_tick_s2 && !bus_tick_s3;

  // a pending request is taken by a bus edge that finds the sequencer idle
  logic capture;
  logic seq_counting;
  assign capture      = bus_edge && strobe_req && delay_cnt == 4'd0 && !pulse_active;
  assign seq_counting = delay_cnt != 4'd0;

  // request held until a bus edge takes it; a hit in the capture cycle or during
  // the delay is covered by the pulse still to come, so it merges instead of
  // queueing a second pulse; a hit during the pulse itself queues a new one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_req <= 1'b0;
    end else if (capture) begin
      strobe_req <= 1'b0;
    end else if (any_hit && bp_control[`ABU_PIN_SEL_BIT] && !seq_counting) begin
      strobe_req <= 1'b1;
    end
  end

  // delay a few bus cycles, then invert the idle level for one bus cycle
  // limitation: a delay of zero never fires, keep PULSE_DELAY at one or more
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_cnt    <= 4'd0;
      pulse_active <= 1'b0;
    end else if (bus_edge) begin
      if (pulse_active) begin
        pulse_active <= 1'b0;
      end else if (delay_cnt != 4'd0) begin
        if (delay_cnt == 4'd1) begin
          pulse_active <= 1'b1;
        end
        delay_cnt <= delay_cnt - 4'd1;
      end else if (strobe_req) begin
        delay_cnt <= 4'(PULSE_DELAY);
      end
    end
  end

  // registered so the pin never glitches between bus cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      debug_pulse <= 1'b0;
    end else begin
      debug_pulse <= pulse_active ? !pulse_idle_level : pulse_idle_level;
    end
  end

  // count cycles with a taken breakpoint for software visibility
  // wraps silently; software reads differences, not absolute values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_count <= 32'h0000_0000;
    end else if (any_hit) begin
      hit_count <= hit_count + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi write channels: address and data taken in either order
  // ready toggles while idle: a waiting valid is taken within two cycles,
  // traded for a cycle of throughput that this slow register port never needs
  logic do_write;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) && aw_addr != `ABU_OFF_STATUS ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // register updates; compat view writes reach both target and control
  // unmapped offsets and the read-only status word fall to the default arm
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_control          <= `ABU_CTRL_RESET;
      fetch_bp_target     <= `ABU_TARGET_RESET;
      data_bp_target_full <= `ABU_TARGET_RESET;
      pulse_idle_level    <= 1'b0;
    end else if (do_write) begin
      case (aw_addr)
        `ABU_OFF_CONTROL:      bp_control <= merge_bytes(bp_control, w_data, w_strb)
                                             & `ABU_CTRL_WMASK;
        `ABU_OFF_FETCH_TARGET: fetch_bp_target <= merge_bytes(fetch_bp_target, w_data, w_strb);
        `ABU_OFF_DATA_FULL:    data_bp_target_full <= merge_bytes(data_bp_target_full, w_data,
                                                                  w_strb);
        `ABU_OFF_COMPAT_VIEW: begin
          // whole-word semantics: strobes ignored, the alias is one field set
          data_bp_target_full     <= {w_data[31:3], 3'b000};
          bp_control[`ABU_DXLATE_BIT] <= w_data[2];
          bp_control[`ABU_WRITE_BIT]  <= w_data[1];
          bp_control[`ABU_LOAD_BIT]   <= w_data[0];
          bp_control[`ABU_USER_BIT]   <= 1'b1;
          bp_control[`ABU_PRIV_BIT]   <= 1'b1;
        end
        `ABU_OFF_PULSE_CFG:    pulse_idle_level <= w_strb[0] ? w_data[0] : pulse_idle_level;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi read channel: one read at a time, answer one cycle after the address
  // read data is loaded with the address only and stands until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        case (s_axi_araddr)
          `ABU_OFF_CONTROL:      s_axi_rdata <= bp_control;
          `ABU_OFF_FETCH_TARGET: s_axi_rdata <= fetch_bp_target;
          `ABU_OFF_DATA_FULL:    s_axi_rdata <= data_bp_target_full;
          `ABU_OFF_COMPAT_VIEW:  s_axi_rdata <= {data_bp_target_full[31:3],
                                                 bp_control[`ABU_DXLATE_BIT],
                                                 bp_control[`ABU_WRITE_BIT],
                                                 bp_control[`ABU_LOAD_BIT]};
          `ABU_OFF_PULSE_CFG:    s_axi_rdata <= {31'h0000_0000, pulse_idle_level};
          `ABU_OFF_STATUS:       s_axi_rdata <= hit_count;
          default:               s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
